//--- src/misc_decode_pkg.sv
// Constants, encodings and carrier types for the miscellaneous-instruction decoder.
// Assumes one 125 MHz clock, where one execution state is one clock cycle.
`default_nettype none
package misc_decode_pkg;
  localparam int CLOCK_MHZ = 125;
  localparam int STATES_SHORT = 2;
  localparam int MOVE_OVERHEAD = 9;
  localparam int MOVE_PER_BYTE = 4;
  localparam logic [3:0] CNT_SHORT = 4'(STATES_SHORT - 2);
  localparam logic [3:0] CNT_TAIL = 4'(MOVE_OVERHEAD - 2);

  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_SLEEP = 8'h01;
  localparam logic [7:0] OP_STORE_FLAGS = 8'h02;
  localparam logic [7:0] OP_LOAD_FLAGS_REG = 8'h03;
  localparam logic [7:0] OP_OR_FLAGS = 8'h04;
  localparam logic [7:0] OP_XOR_FLAGS = 8'h05;
  localparam logic [7:0] OP_AND_FLAGS = 8'h06;
  localparam logic [7:0] OP_LOAD_FLAGS_IMM = 8'h07;
  localparam logic [7:0] OP_MOVE = 8'h7B;
  localparam logic [7:0] OP_STACK_MOV = 8'h6D;
  localparam logic [7:0] OP_BIT_STORE = 8'h67;
  localparam logic [7:0] OP_BIT_GROUP = 8'h74;
  localparam logic [7:0] OP_BIT_GROUP_MASK = 8'hFC;
  localparam logic [3:0] SP_INDEX = 4'h7;

  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam int SEL_BIT = 7;

  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_H = 5;
  localparam logic [7:0] FLAGS_RESET = 8'h80;

  typedef enum logic [3:0] {
    CLS_OTHER = 4'h0, CLS_NOP = 4'h1, CLS_SLEEP = 4'h2, CLS_LOAD_IMM = 4'h3,
    CLS_LOAD_REG = 4'h4, CLS_STORE = 4'h5, CLS_AND = 4'h6, CLS_OR = 4'h7,
    CLS_XOR = 4'h8, CLS_MOVE = 4'h9, CLS_STACK_MOV = 4'hA, CLS_BIT_PLAIN = 4'hB,
    CLS_BIT_INVERT = 4'hC
  } instr_class_t;

  typedef struct packed {
    instr_class_t cls;
    logic [7:0] opcode;
    logic sel;
  } decode_t;

  typedef enum logic [2:0] {
    AR_NONE = 3'h0, AR_WORD = 3'h1, AR_ADD_CARRY = 3'h2, AR_SUB_CARRY = 3'h3,
    AR_DECIMAL = 3'h4, AR_DIVIDE = 3'h5
  } arith_kind_t;

  typedef struct packed {
    arith_kind_t kind;
    logic carry_bit11;
    logic carry;
    logic neg;
    logic zero;
    logic ovf;
    logic decimal_carry;
    logic divisor_neg;
    logic divisor_zero;
  } arith_t;

  function automatic decode_t decode_word(input logic [15:0] word);
    decode_t d;
    d.opcode = word[OPC_HI:OPC_LO];
    d.sel = word[SEL_BIT];
    d.cls = CLS_OTHER;
    case (d.opcode)
      OP_NOP: d.cls = CLS_NOP;
      OP_SLEEP: d.cls = CLS_SLEEP;
      OP_STORE_FLAGS: d.cls = CLS_STORE;
      OP_LOAD_FLAGS_REG: d.cls = CLS_LOAD_REG;
      OP_OR_FLAGS: d.cls = CLS_OR;
      OP_XOR_FLAGS: d.cls = CLS_XOR;
      OP_AND_FLAGS: d.cls = CLS_AND;
      OP_LOAD_FLAGS_IMM: d.cls = CLS_LOAD_IMM;
      OP_MOVE: d.cls = CLS_MOVE;
      OP_STACK_MOV: d.cls = (word[6:4] == SP_INDEX[2:0]) ? CLS_STACK_MOV : CLS_OTHER;
      default: d.cls = CLS_OTHER;
    endcase
    if (d.opcode == OP_BIT_STORE || (d.opcode & OP_BIT_GROUP_MASK) == OP_BIT_GROUP) begin
      d.cls = d.sel ? CLS_BIT_INVERT : CLS_BIT_PLAIN;
    end
    return d;
  endfunction : decode_word
endpackage : misc_decode_pkg
`default_nettype wire

//--- src/flag_unit.sv
// Condition flags register with the special arithmetic update cases.
// Assumes the arithmetic unit reports one result per cycle on arith_in.
`default_nettype none
module flag_unit import misc_decode_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_val_in,
  input wire arith_t arith_in,
  output logic [7:0] flags_out
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;

  always_comb begin
    flags_d = flags_q;
    if (wr_en_in) begin
      flags_d = wr_val_in;
    end else begin
      unique case (arith_in.kind)
        AR_WORD: begin
          flags_d[FLAG_H] = arith_in.carry_bit11;
          flags_d[FLAG_N] = arith_in.neg;
          flags_d[FLAG_Z] = arith_in.zero;
          flags_d[FLAG_V] = arith_in.ovf;
          flags_d[FLAG_C] = arith_in.carry;
        end
        AR_ADD_CARRY, AR_SUB_CARRY: begin
          // Keeping Z on a zero byte lets a chain of bytes test the whole word for zero.
          flags_d[FLAG_Z] = arith_in.zero ? flags_q[FLAG_Z] : 1'b0;
          flags_d[FLAG_N] = arith_in.neg;
          flags_d[FLAG_V] = arith_in.ovf;
          flags_d[FLAG_C] = arith_in.carry;
        end
        AR_DECIMAL: begin
          flags_d[FLAG_C] = arith_in.decimal_carry ? 1'b1 : flags_q[FLAG_C];
          flags_d[FLAG_N] = arith_in.neg;
          flags_d[FLAG_Z] = arith_in.zero;
        end
        AR_DIVIDE: begin
          flags_d[FLAG_N] = arith_in.divisor_neg;
          flags_d[FLAG_Z] = arith_in.divisor_zero;
        end
        default: flags_d = flags_q;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_out = flags_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  chk_half_carry_word: assert property (!wr_en_in && arith_in.kind == AR_WORD |=>
    flags_out[FLAG_H] == $past(arith_in.carry_bit11)) else $error("Half carry does not follow bit 11.");
  chk_zero_retain: assert property (!wr_en_in && (arith_in.kind == AR_ADD_CARRY ||
    arith_in.kind == AR_SUB_CARRY) |=> flags_out[FLAG_Z] == ($past(arith_in.zero) && $past(flags_out[FLAG_Z])))
    else $error("Zero flag wrong after carry arithmetic.");
  chk_decimal_carry: assert property (!wr_en_in && arith_in.kind == AR_DECIMAL |=>
    flags_out[FLAG_C] == ($past(arith_in.decimal_carry) || $past(flags_out[FLAG_C])))
    else $error("Decimal adjust carry wrong.");
  chk_divide_flags: assert property (!wr_en_in && arith_in.kind == AR_DIVIDE |=>
    flags_out[FLAG_N] == $past(arith_in.divisor_neg) && flags_out[FLAG_Z] == $past(arith_in.divisor_zero))
    else $error("Divide flags wrong.");
endmodule : flag_unit
`default_nettype wire

//--- src/cpu_misc_instr_decode.sv
// Decode and execution of the system-control and miscellaneous instructions.
// Assumes instruction words, operands and memory read data come from logic on the same clock,
// and that memory returns read data in the cycle after a read strobe.
`default_nettype none
module cpu_misc_instr_decode import misc_decode_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_word_in,
  output logic instr_ready_out,
  input wire logic [7:0] reg_byte_in,
  input wire logic [7:0] move_count_in,
  input wire logic [15:0] source_ptr_in,
  input wire logic [15:0] dest_ptr_in,
  input wire arith_t arith_in,
  input wire logic wake_in,
  output decode_t decode_out,
  output logic done_out,
  output logic [7:0] flags_out,
  output logic reg_wr_out,
  output logic [3:0] reg_wr_idx_out,
  output logic [7:0] reg_wr_data_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  output logic [15:0] source_ptr_out,
  output logic [15:0] dest_ptr_out,
  output logic [7:0] move_count_out,
  output logic sleep_out
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_EXEC = 6'b000010, S_READ = 6'b000100,
    S_CAPTURE = 6'b001000, S_WRITE = 6'b010000, S_STEP = 6'b100000
  } state_t;

  state_t state_q;
  logic [3:0] cnt_q;
  decode_t decode_q;
  decode_t dec;
  logic [7:0] imm_q;
  logic [7:0] rs_q;
  logic [3:0] rd_idx_q;
  logic [15:0] src_q;
  logic [15:0] dst_q;
  logic [7:0] count_q;
  logic [7:0] data_q;
  logic sleep_q;
  logic accept;
  logic executes;
  logic flag_wr;
  logic [7:0] flag_val;

  assign dec = decode_word(instr_word_in);
  assign instr_ready_out = (state_q == S_IDLE);
  assign accept = instr_valid_in && instr_ready_out;
  assign executes = dec.cls inside {CLS_NOP, CLS_SLEEP, CLS_LOAD_IMM, CLS_LOAD_REG, CLS_STORE,
                                    CLS_AND, CLS_OR, CLS_XOR, CLS_MOVE};
  assign done_out = (state_q == S_EXEC) && (cnt_q == 4'h0);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (accept && executes) begin
            if (dec.cls == CLS_MOVE && move_count_in != 8'h00) begin
              state_q <= S_READ;
            end else begin
              state_q <= S_EXEC;
              cnt_q <= (dec.cls == CLS_MOVE) ? CNT_TAIL : CNT_SHORT;
            end
          end
        end
        S_EXEC: begin
          if (cnt_q == 4'h0) begin
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_READ: state_q <= S_CAPTURE;
        S_CAPTURE: state_q <= S_WRITE;
        S_WRITE: state_q <= S_STEP;
        S_STEP: begin
          if (count_q == 8'h01) begin
            state_q <= S_EXEC;
            cnt_q <= CNT_TAIL;
          end else begin
            state_q <= S_READ;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      decode_q <= '0;
      imm_q <= 8'h00;
      rs_q <= 8'h00;
      rd_idx_q <= 4'h0;
    end else if (accept) begin
      decode_q <= dec;
      imm_q <= instr_word_in[7:0];
      rs_q <= reg_byte_in;
      rd_idx_q <= instr_word_in[3:0];
    end
  end

  // The byte move keeps its own copies of pointers and count so the register file is free meanwhile.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_q <= 16'h0000;
      dst_q <= 16'h0000;
      count_q <= 8'h00;
      data_q <= 8'h00;
    end else if (accept && dec.cls == CLS_MOVE) begin
      src_q <= source_ptr_in;
      dst_q <= dest_ptr_in;
      count_q <= move_count_in;
    end else if (state_q == S_CAPTURE) begin
      data_q <= mem_rdata_in;
    end else if (state_q == S_STEP) begin
      src_q <= src_q + 16'h0001;
      dst_q <= dst_q + 16'h0001;
      count_q <= count_q - 8'h01;
    end
  end

  assign mem_rd_out = (state_q == S_READ);
  assign mem_wr_out = (state_q == S_WRITE);
  assign mem_addr_out = (state_q == S_WRITE) ? dst_q : src_q;
  assign mem_wdata_out = data_q;
  assign source_ptr_out = src_q;
  assign dest_ptr_out = dst_q;
  assign move_count_out = count_q;

  always_comb begin
    flag_wr = done_out;
    unique case (decode_q.cls)
      CLS_LOAD_IMM: flag_val = imm_q;
      CLS_LOAD_REG: flag_val = rs_q;
      CLS_AND: flag_val = flags_out & imm_q;
      CLS_OR: flag_val = flags_out | imm_q;
      CLS_XOR: flag_val = flags_out ^ imm_q;
      default: begin
        flag_wr = 1'b0;
        flag_val = flags_out;
      end
    endcase
  end

  flag_unit flags_i (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(flag_wr),
    .wr_val_in(flag_val),
    .arith_in(arith_in),
    .flags_out(flags_out)
  );

  assign reg_wr_out = done_out && decode_q.cls == CLS_STORE;
  assign reg_wr_idx_out = rd_idx_q;
  assign reg_wr_data_out = flags_out;

  // Entering sleep wins over a wake in the same cycle, so the instruction is never lost.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_q <= 1'b0;
    end else if (done_out && decode_q.cls == CLS_SLEEP) begin
      sleep_q <= 1'b1;
    end else if (wake_in) begin
      sleep_q <= 1'b0;
    end
  end

  assign sleep_out = sleep_q;
  assign decode_out = decode_q;

  logic [11:0] mv_cycles_q;
  logic [7:0] mv_n_q;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mv_cycles_q <= 12'h000;
      mv_n_q <= 8'h00;
    end else if (accept) begin
      mv_cycles_q <= 12'h001;
      mv_n_q <= move_count_in;
    end else if (state_q != S_IDLE) begin
      mv_cycles_q <= mv_cycles_q + 12'h001;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_byte_copy;
    mem_rd_out ##1 (!mem_rd_out && !mem_wr_out) ##1 mem_wr_out ##1 (!mem_wr_out && !mem_rd_out);
  endsequence
  sequence s_short_finish;
    (done_out && !instr_ready_out) ##1 instr_ready_out;
  endsequence

  chk_sleep_entry: assert property (accept && dec.cls == CLS_SLEEP |=> s_short_finish ##0 sleep_out)
    else $error("Sleep not entered after 2 states.");
  chk_move_total: assert property (done_out && decode_q.cls == CLS_MOVE |->
    mv_cycles_q == 12'(MOVE_PER_BYTE) * 12'(mv_n_q) + 12'(MOVE_OVERHEAD - 1))
    else $error("Byte move total time wrong.");
  chk_move_sequence: assert property (mem_rd_out |-> s_byte_copy)
    else $error("Byte move steps out of order.");
  chk_move_data: assert property (mem_wr_out |-> mem_wdata_out == $past(mem_rdata_in) &&
    mem_addr_out == dst_q) else $error("Moved byte differs from the byte read.");
  chk_move_step: assert property (mem_wr_out |=> ##1 source_ptr_out == $past(source_ptr_out, 2) + 16'h0001 &&
    move_count_out == $past(move_count_out, 2) - 8'h01) else $error("Pointers or count did not step.");
  chk_opcode_byte: assert property (accept |=> decode_out.opcode == $past(instr_word_in[15:8]))
    else $error("Opcode not taken from the first byte.");
  chk_bit7_select: assert property (accept && dec.cls inside {CLS_BIT_PLAIN, CLS_BIT_INVERT} |=>
    (decode_out.cls == CLS_BIT_INVERT) == $past(instr_word_in[7])) else $error("Bit 7 selection wrong.");
  chk_stack_move: assert property (accept && instr_word_in[15:8] == OP_STACK_MOV &&
    instr_word_in[6:4] == SP_INDEX[2:0] |=> decode_out.cls == CLS_STACK_MOV) else $error("Push or pop misdecoded.");
  chk_flag_load: assert property (accept && dec.cls == CLS_LOAD_IMM |=> done_out ##1
    flags_out == $past(imm_q)) else $error("Flag load wrong.");
  chk_store_flags: assert property (accept && dec.cls == CLS_STORE |=> reg_wr_out &&
    reg_wr_data_out == flags_out && reg_wr_idx_out == $past(instr_word_in[3:0]))
    else $error("Flag store not issued in 2 states.");
  chk_nop_quiet: assert property (accept && dec.cls == CLS_NOP && arith_in.kind == AR_NONE |=>
    done_out && !reg_wr_out && !mem_wr_out && flags_out == $past(flags_out)) else $error("No-op changed state.");
endmodule : cpu_misc_instr_decode
`default_nettype wire

//--- test/mem_model.sv
// Behavioural data memory that answers the decoder's byte reads during a block move.
// Assumes the read strobe and address are sampled at the rising edge, data wanted the next cycle.
`default_nettype none
module mem_model (
  input wire logic clock_in,
  input wire logic rd_in,
  input wire logic [15:0] addr_in,
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Outside the answer cycle the bus inverts every cycle, so a sample one cycle late does not match.
  always @(posedge clock_in) begin
    rdata_out <= rd_in ? (addr_in[7:0] ^ addr_in[15:8] ^ 8'h5A) : ~rdata_out;
  end
endmodule : mem_model
`default_nettype wire

//--- test/cpu_misc_instr_decode_tb.sv
// Self-checking bench for the miscellaneous-instruction decoder with a behavioural reference.
// Assumes the memory model above; inputs change 1 ns after the rising edge.
`default_nettype none
module cpu_misc_instr_decode_tb import misc_decode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic valid = 1'b0;
  logic wake = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [15:0] src = 16'h0000;
  logic [15:0] dst = 16'h0000;
  logic [7:0] rbyte = 8'h00;
  logic [7:0] cnt = 8'h00;
  arith_t arith = '0;
  logic ready, done, reg_wr, mem_rd, mem_wr, sleep;
  decode_t dec;
  logic [7:0] flags, wdata, mwdata, rdata, cnt_o;
  logic [3:0] widx;
  logic [15:0] maddr, sp_o, dp_o;
  // Expected block-move writes, each entry holding the destination address above the byte.
  logic [23:0] wq [$];
  logic [23:0] ew = 24'h000000;
  logic [7:0] fop [6] = '{OP_LOAD_FLAGS_IMM, OP_LOAD_FLAGS_REG, OP_AND_FLAGS, OP_OR_FLAGS, OP_XOR_FLAGS,
    OP_STORE_FLAGS};
  logic [7:0] dop [8] = '{8'h6D, 8'h67, 8'h74, 8'h75, 8'h76, 8'h77, 8'h6E, 8'h08};
  logic [7:0] ef = FLAGS_RESET;
  int mismatches = 0;
  int tests_run = 0;
  int wcnt = 0;
  always #4 clock_in = ~clock_in;
  cpu_misc_instr_decode dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .instr_valid_in(valid),
    .instr_word_in(word), .instr_ready_out(ready), .reg_byte_in(rbyte), .move_count_in(cnt),
    .source_ptr_in(src), .dest_ptr_in(dst), .arith_in(arith), .wake_in(wake), .decode_out(dec),
    .done_out(done), .flags_out(flags), .reg_wr_out(reg_wr), .reg_wr_idx_out(widx),
    .reg_wr_data_out(wdata), .mem_rd_out(mem_rd), .mem_wr_out(mem_wr), .mem_addr_out(maddr),
    .mem_wdata_out(mwdata), .mem_rdata_in(rdata), .source_ptr_out(sp_o), .dest_ptr_out(dp_o),
    .move_count_out(cnt_o), .sleep_out(sleep));
  mem_model mem (.clock_in(clock_in), .rd_in(mem_rd), .addr_in(maddr), .rdata_out(rdata));
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // Bits 6 and 4 have no defined meaning here, so they are left out of flag comparisons.
  task automatic chkf(input int b);
    if (b < 0) chk(16'(flags & 8'hAF), 16'(ef & 8'hAF), "flags");
    else chk(16'(flags[b]), 16'(ef[b]), "flag bit");
  endtask : chkf
  task automatic step;
    @(posedge clock_in);
    #1;
  endtask : step
  function automatic instr_class_t ecls(input logic [15:0] w);
    if (w[15:8] == 8'h67 || w[15:10] == 6'b011101) return w[7] ? CLS_BIT_INVERT : CLS_BIT_PLAIN;
    case (w[15:8])
      OP_NOP: return CLS_NOP;
      OP_SLEEP: return CLS_SLEEP;
      OP_STORE_FLAGS: return CLS_STORE;
      OP_LOAD_FLAGS_REG: return CLS_LOAD_REG;
      OP_OR_FLAGS: return CLS_OR;
      OP_XOR_FLAGS: return CLS_XOR;
      OP_AND_FLAGS: return CLS_AND;
      OP_LOAD_FLAGS_IMM: return CLS_LOAD_IMM;
      OP_MOVE: return CLS_MOVE;
      OP_STACK_MOV: return (w[6:4] == 3'h7) ? CLS_STACK_MOV : CLS_OTHER;
      default: return CLS_OTHER;
    endcase
  endfunction : ecls
  task automatic issue(input logic [15:0] w);
    instr_class_t c;
    int cyc;
    c = ecls(w);
    word = w;
    valid = 1'b1;
    step;
    valid = 1'b0;
    chk(16'(dec.cls), 16'(c), "class");
    chk(16'(dec.opcode), 16'(w[15:8]), "opcode");
    chk(16'(dec.sel), 16'(w[7]), "select bit");
    if (c inside {CLS_OTHER, CLS_STACK_MOV, CLS_BIT_PLAIN, CLS_BIT_INVERT}) begin
      chk(16'({ready, done}), 16'h2, "no execution");
      step;
      return;
    end
    cyc = 1;
    while (done !== 1'b1 && cyc < 2000) begin
      step;
      cyc++;
    end
    chk(16'(cyc + 1), 16'((c == CLS_MOVE) ? 4 * cnt + 9 : 2), "states");
    if (c == CLS_STORE) chk(16'({reg_wr, widx, wdata & 8'hAF}), 16'({1'b1, w[3:0], ef & 8'hAF}), "store");
    case (c)
      CLS_LOAD_IMM: ef = w[7:0];
      CLS_LOAD_REG: ef = rbyte;
      CLS_AND: ef = ef & w[7:0];
      CLS_OR: ef = ef | w[7:0];
      CLS_XOR: ef = ef ^ w[7:0];
      default: ;
    endcase
    step;
    chkf(-1);
  endtask : issue
  task automatic alu(input arith_kind_t k);
    int b;
    issue({OP_LOAD_FLAGS_IMM, 8'($urandom)});
    arith = arith_t'($urandom);
    arith.kind = k;
    case (k)
      AR_WORD: begin ef[FLAG_H] = arith.carry_bit11; b = FLAG_H; end
      AR_DECIMAL: begin ef[FLAG_C] = ef[FLAG_C] | arith.decimal_carry; b = FLAG_C; end
      AR_DIVIDE: begin ef[FLAG_N] = arith.divisor_neg; ef[FLAG_Z] = arith.divisor_zero; b = FLAG_N; end
      default: begin ef[FLAG_Z] = ef[FLAG_Z] & arith.zero; b = FLAG_Z; end
    endcase
    step;
    arith.kind = AR_NONE;
    chkf(b);
    if (k == AR_DIVIDE) chkf(FLAG_Z);
  endtask : alu
  task automatic mv(input logic [7:0] n);
    logic [15:0] pa;
    src = 16'($urandom);
    dst = 16'($urandom);
    cnt = n;
    wcnt = 0;
    for (int i = 0; i < int'(n); i++) begin
      pa = src + 16'(i);
      wq.push_back({dst + 16'(i), pa[7:0] ^ pa[15:8] ^ 8'h5A});
    end
    issue({OP_MOVE, 8'h00});
    chk(16'(wcnt), 16'(n), "bytes moved");
    chk(16'(wq.size()), 16'h0000, "writes outstanding");
    chk(sp_o, src + 16'(n), "source pointer");
    chk(dp_o, dst + 16'(n), "dest pointer");
    chk(16'(cnt_o), 16'h0000, "count");
  endtask : mv
  always @(posedge clock_in) begin
    if (mem_wr === 1'b1) begin
      chk(16'(wq.size() != 0), 16'h0001, "write expected");
      if (wq.size() != 0) ew = wq.pop_front();
      chk(maddr, ew[23:8], "write address");
      chk(16'(mwdata), 16'(ew[7:0]), "write data");
      wcnt++;
    end
  end
  initial begin
    #400000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    test_done;
  end
  initial begin
    void'($urandom(32'h60f8c676));
    repeat (10) @(posedge clock_in);
    #1 rst_n_in = 1'b1;
    chkf(-1);
    chk(16'(ready), 16'h1, "ready after reset");
    issue(16'h0000);
    issue({OP_SLEEP, 8'h00});
    chk(16'(sleep), 16'h1, "sleep entered");
    wake = 1'b1;
    step;
    wake = 1'b0;
    chk(16'(sleep), 16'h0, "woken");
    for (int r = 0; r < 18; r++) begin
      rbyte = 8'($urandom);
      issue({fop[r % 6], 8'($urandom)});
    end
    issue({OP_SLEEP, 8'($urandom)});
    chk(16'(sleep), 16'h1, "sleep before reset");
    rst_n_in = 1'b0;
    step;
    ef = FLAGS_RESET;
    chk(16'({sleep, ready, done}), 16'h2, "state in reset");
    chkf(-1);
    rst_n_in = 1'b1;
    step;
    chk(16'({sleep, ready, done}), 16'h2, "state after reset");
    chkf(-1);
    for (int r = 0; r < 20; r++) alu(arith_kind_t'(1 + r % 5));
    mv(8'h00);
    mv(8'h01);
    mv(8'h03);
    mv(8'($urandom_range(2, 9)));
    issue(16'h6DF0);
    issue(16'h6D20);
    for (int r = 0; r < 24; r++) issue({dop[$urandom % 8], 8'($urandom)});
    test_done;
  end
endmodule : cpu_misc_instr_decode_tb
`default_nettype wire
